// ### pabm_pkg.sv
// package of constants for the port a/b alternate function multiplexer
package pabm_pkg;
	localparam int PIN_COUNT = 8;
	// register map, bus offsets
	localparam logic [3:0] ADDR_MISC_CTRL = 4'h0;
	localparam logic [3:0] ADDR_PORTA_DIR = 4'h1;
	localparam logic [3:0] ADDR_PORTA_OUT = 4'h2;
	localparam logic [3:0] ADDR_PORTA_IN = 4'h3;
	localparam logic [3:0] ADDR_PORTB_DIR = 4'h4;
	localparam logic [3:0] ADDR_PORTB_OUT = 4'h5;
	localparam logic [3:0] ADDR_PORTB_IN = 4'h6;
	localparam logic [3:0] ADDR_PERIPH_CTRL = 4'h7;
	// misc_function_control fields
	localparam int MISC_PULLUP_OFF_BIT = 2;
	localparam logic [7:0] MISC_CTRL_RESET = 8'h00;
	localparam logic [7:0] MISC_CTRL_WMASK = 8'hEF;
	// periph_ctrl fields
	localparam int PER_SPI_ON_BIT = 0;
	localparam int PER_SPI_MASTER_BIT = 1;
	localparam int PER_SYNC_SEL_BIT = 2;
	localparam int PER_T0_CMP_EN_BIT = 3;
	localparam int PER_IRQ2_EN_BIT = 4;
	localparam logic [7:0] PERIPH_CTRL_WMASK = 8'h1F;
	localparam logic [7:0] PORT_RESET = 8'h00;
	// pin positions on port b
	localparam int PB_SCK = 7;
	localparam int PB_MISO = 6;
	localparam int PB_MOSI = 5;
	localparam int PB_SEL = 4;
	localparam int PB_T0CMP = 3;
	localparam int PB_IRQ2 = 2;
	localparam int PB_T1CNT = 1;
	localparam int PB_SCLK = 0;
endpackage

// ### pabm_pin_ctrl.sv
// one pin's override merge into pull-up, driver, level and input enable
`timescale 1ns/1ps
module pabm_pin_ctrl (
	input wire logic pin_direction_bit,
	input wire logic pin_output_bit,
	input wire logic global_pullup_off,
	input wire logic sleep_active,
	input wire logic pullup_override_en,
	input wire logic pullup_override_val,
	input wire logic direction_override_en,
	input wire logic direction_override_val,
	input wire logic value_override_en,
	input wire logic value_override_val,
	input wire logic input_enable_override_en,
	input wire logic input_enable_override_val,
	output logic pullup_on,
	output logic drive_on,
	output logic drive_level,
	output logic input_on
);
	// pull-up only for input, output bit one, global disable clear
	assign pullup_on = pullup_override_en ? pullup_override_val :
		(!pin_direction_bit && pin_output_bit && !global_pullup_off); // see RL18 RL1
	assign drive_on = direction_override_en ? direction_override_val :
		pin_direction_bit; // see RL19
	// level is don't-care while undriven; forced low then
	assign drive_level = drive_on &&
		(value_override_en ? value_override_val : pin_output_bit); // see RL20
	assign input_on = input_enable_override_en ? input_enable_override_val :
		!sleep_active; // see RL21
endmodule

// ### pabm_reg8.sv
// eight-bit software register with write mask and reset value
`timescale 1ns/1ps
module pabm_reg8 #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WMASK = 8'hFF
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] value_reg
);
	always_ff @(posedge clk) begin
		if (reset) begin
			value_reg <= RESET_VAL;
		end else if (wr_en) begin
			value_reg <= wr_data & WMASK;
		end
	end
endmodule

// ### pabm_top.sv
// top of the port a/b alternate function multiplexer
//
// Summary of operation
// RL1: global pull-up off bit set disables every port pull-up.
// RL2: control register resets to zero; bit 4 reads zero, not writable.
// RL3: port a pins pass analog channel n; no overrides asserted.
// RL4: software keeps port a outputs still during a conversion.
// RL5: spi clock pin forced input as slave; direction bit as master.
// RL6: miso pin forced input as master; direction bit as slave.
// RL7: mosi pin forced input as slave; direction bit as master.
// RL8: select pin forced input as slave; slave active while it is low.
// RL9: spi-forced inputs keep pull-up from output bit, gated by global off.
// RL10: miso/mosi carry data; driven value chosen by spi role.
// RL11: bit 3 drives timer-0 compare when enabled; software sets output.
// RL12: timer-0 compare pin also carries its pwm output.
// RL13: software sets comparator pins as inputs, pull-ups off.
// RL14: bit 2 feeds irq 2; enabled irq forces digital input on.
// RL15: bit 1 gives raw input as timer-1 count source.
// RL16: bit 0 direction bit picks serial clock out or in; timer-0 count.
// RL17: serial clock only in sync mode, overriding the output value.
// RL18: pull-up override wins, else input, output one, global off clear.
// RL19: direction override wins, else the pin's direction bit.
// RL20: value override wins while driving, else the output bit.
// RL21: input-enable override wins over normal or sleep state.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module pabm_top (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic SLEEP_ACTIVE,
	input wire logic [7:0] PA_PIN_IN,
	output logic [7:0] PA_PIN_OUT,
	output logic [7:0] PA_PIN_OE_N,
	output logic [7:0] PA_PULLUP,
	output logic [7:0] PA_ANALOG_PATH,
	input wire logic [7:0] PB_PIN_IN,
	output logic [7:0] PB_PIN_OUT,
	output logic [7:0] PB_PIN_OE_N,
	output logic [7:0] PB_PULLUP,
	input wire logic SPI_CLK_OUT,
	input wire logic SPI_MASTER_OUT,
	input wire logic SPI_SLAVE_OUT,
	output logic SPI_CLK_IN,
	output logic SPI_MASTER_IN,
	output logic SPI_SLAVE_IN,
	output logic SPI_SLAVE_ACTIVE,
	input wire logic TIMER0_COMPARE_OUT,
	output logic COMPARATOR_POS_IN,
	output logic COMPARATOR_NEG_IN,
	output logic EXT_IRQ2_IN,
	output logic TIMER1_COUNT_IN,
	output logic TIMER0_COUNT_IN,
	input wire logic SERIAL_PORT_CLOCK_OUT,
	output logic SERIAL_PORT_CLOCK_IN,
	output logic [2:0] CONV_TRIGGER_SEL,
	output logic COMPARATOR_MUX_EN,
	output logic TIMER2_PRESCALE_RESET,
	output logic TIMER10_PRESCALE_RESET
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] misc_ctrl_reg;
	logic [7:0] pa_dir_reg;
	logic [7:0] pa_out_reg;
	logic [7:0] pb_dir_reg;
	logic [7:0] pb_out_reg;
	logic [7:0] periph_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] pa_in_gated;
	logic [7:0] pb_in_gated;
	logic global_pullup_off;
	logic spi_on_bit;
	logic spi_master_select;
	logic spi_master_mode;
	logic spi_slave_mode;
	logic serial_sync_select;
	logic timer0_cmp_en;
	logic ext_irq2_en;
	logic [7:0] pa_input_on;
	logic [7:0] pb_input_on;
	logic [7:0] pa_drive_on;
	logic [7:0] pb_drive_on;
	logic [7:0] pb_pullup_override_en;
	logic [7:0] pb_pullup_override_val;
	logic [7:0] pb_direction_override_en;
	logic [7:0] pb_value_override_en;
	logic [7:0] pb_value_override_val;
	logic [7:0] pb_input_enable_override_en;
	logic [7:0] pb_input_enable_override_val;

	// bit 4 masked on write so it always reads zero
	pabm_reg8 #(.RESET_VAL(pabm_pkg::MISC_CTRL_RESET),
		.WMASK(pabm_pkg::MISC_CTRL_WMASK)) u_misc ( // see RL2
		.clk(CLK), .reset(RESET),
		.wr_en(WR && ADDR == pabm_pkg::ADDR_MISC_CTRL),
		.wr_data(WDATA), .value_reg(misc_ctrl_reg));
	pabm_reg8 #(.RESET_VAL(pabm_pkg::PORT_RESET)) u_pa_dir (
		.clk(CLK), .reset(RESET),
		.wr_en(WR && ADDR == pabm_pkg::ADDR_PORTA_DIR),
		.wr_data(WDATA), .value_reg(pa_dir_reg));
	pabm_reg8 #(.RESET_VAL(pabm_pkg::PORT_RESET)) u_pa_out (
		.clk(CLK), .reset(RESET),
		.wr_en(WR && ADDR == pabm_pkg::ADDR_PORTA_OUT),
		.wr_data(WDATA), .value_reg(pa_out_reg));
	pabm_reg8 #(.RESET_VAL(pabm_pkg::PORT_RESET)) u_pb_dir (
		.clk(CLK), .reset(RESET),
		.wr_en(WR && ADDR == pabm_pkg::ADDR_PORTB_DIR),
		.wr_data(WDATA), .value_reg(pb_dir_reg));
	pabm_reg8 #(.RESET_VAL(pabm_pkg::PORT_RESET)) u_pb_out (
		.clk(CLK), .reset(RESET),
		.wr_en(WR && ADDR == pabm_pkg::ADDR_PORTB_OUT),
		.wr_data(WDATA), .value_reg(pb_out_reg));
	pabm_reg8 #(.RESET_VAL(pabm_pkg::PORT_RESET),
		.WMASK(pabm_pkg::PERIPH_CTRL_WMASK)) u_periph (
		.clk(CLK), .reset(RESET),
		.wr_en(WR && ADDR == pabm_pkg::ADDR_PERIPH_CTRL),
		.wr_data(WDATA), .value_reg(periph_reg));

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_comb begin
		case (ADDR)
			pabm_pkg::ADDR_MISC_CTRL: rdata_next = misc_ctrl_reg;
			pabm_pkg::ADDR_PORTA_DIR: rdata_next = pa_dir_reg;
			pabm_pkg::ADDR_PORTA_OUT: rdata_next = pa_out_reg;
			pabm_pkg::ADDR_PORTA_IN: rdata_next = pa_in_gated;
			pabm_pkg::ADDR_PORTB_DIR: rdata_next = pb_dir_reg;
			pabm_pkg::ADDR_PORTB_OUT: rdata_next = pb_out_reg;
			pabm_pkg::ADDR_PORTB_IN: rdata_next = pb_in_gated;
			pabm_pkg::ADDR_PERIPH_CTRL: rdata_next = periph_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK) begin
		if (RESET) begin
			rdata_reg <= 8'h00;
		end else if (RD) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign RDATA = rdata_reg;

	// ----------------------------------------------------------------
	// control decode
	// ----------------------------------------------------------------
	assign global_pullup_off = misc_ctrl_reg[pabm_pkg::MISC_PULLUP_OFF_BIT];
	assign CONV_TRIGGER_SEL = misc_ctrl_reg[7:5];
	assign COMPARATOR_MUX_EN = misc_ctrl_reg[3];
	assign TIMER2_PRESCALE_RESET = misc_ctrl_reg[1];
	assign TIMER10_PRESCALE_RESET = misc_ctrl_reg[0];
	assign spi_on_bit = periph_reg[pabm_pkg::PER_SPI_ON_BIT];
	assign spi_master_select = periph_reg[pabm_pkg::PER_SPI_MASTER_BIT];
	assign serial_sync_select = periph_reg[pabm_pkg::PER_SYNC_SEL_BIT];
	assign timer0_cmp_en = periph_reg[pabm_pkg::PER_T0_CMP_EN_BIT];
	assign ext_irq2_en = periph_reg[pabm_pkg::PER_IRQ2_EN_BIT];
	assign spi_master_mode = spi_on_bit && spi_master_select;
	assign spi_slave_mode = spi_on_bit && !spi_master_select;

	// ----------------------------------------------------------------
	// port a: analog inputs, no overrides
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < pabm_pkg::PIN_COUNT; gi++) begin : g_pa
			pabm_pin_ctrl u_pin ( // see RL3
				.pin_direction_bit(pa_dir_reg[gi]),
				.pin_output_bit(pa_out_reg[gi]),
				.global_pullup_off(global_pullup_off),
				.sleep_active(SLEEP_ACTIVE),
				.pullup_override_en(1'b0),
				.pullup_override_val(1'b0),
				.direction_override_en(1'b0),
				.direction_override_val(1'b0),
				.value_override_en(1'b0),
				.value_override_val(1'b0),
				.input_enable_override_en(1'b0),
				.input_enable_override_val(1'b0),
				.pullup_on(PA_PULLUP[gi]),
				.drive_on(pa_drive_on[gi]),
				.drive_level(PA_PIN_OUT[gi]),
				.input_on(pa_input_on[gi]));
		end
	endgenerate
	assign PA_PIN_OE_N = ~pa_drive_on;
	assign pa_in_gated = PA_PIN_IN & pa_input_on;
	// pad level routed straight to converter channel n
	assign PA_ANALOG_PATH = PA_PIN_IN; // see RL3

	// ----------------------------------------------------------------
	// port b override signals
	// ----------------------------------------------------------------
	// pull-up override sits on whichever spi pins are forced to input
	always_comb begin
		pb_pullup_override_en = 8'h00;
		pb_pullup_override_val = 8'h00;
		pb_direction_override_en = 8'h00;
		pb_value_override_en = 8'h00;
		pb_value_override_val = 8'h00;
		pb_input_enable_override_en = 8'h00;
		pb_input_enable_override_val = 8'h00;
		// spi clock, mosi, select forced input as slave
		pb_direction_override_en[pabm_pkg::PB_SCK] = spi_slave_mode; // see RL5
		pb_direction_override_en[pabm_pkg::PB_MOSI] = spi_slave_mode; // see RL7
		pb_direction_override_en[pabm_pkg::PB_SEL] = spi_slave_mode; // see RL8
		// miso forced input as master
		pb_direction_override_en[pabm_pkg::PB_MISO] = spi_master_mode; // see RL6
		// pull-up of a forced input tracks output bit, gated globally
		pb_pullup_override_en[pabm_pkg::PB_SCK] = spi_slave_mode; // see RL9
		pb_pullup_override_en[pabm_pkg::PB_MOSI] = spi_slave_mode; // see RL9
		pb_pullup_override_en[pabm_pkg::PB_SEL] = spi_slave_mode; // see RL9
		pb_pullup_override_en[pabm_pkg::PB_MISO] = spi_master_mode; // see RL9
		pb_pullup_override_val[7:4] = pb_out_reg[7:4] & {4{!global_pullup_off}}; // see RL9
		// driven values follow role: master drives clock and mosi
		pb_value_override_en[pabm_pkg::PB_SCK] = spi_master_mode;
		pb_value_override_val[pabm_pkg::PB_SCK] = SPI_CLK_OUT;
		pb_value_override_en[pabm_pkg::PB_MOSI] = spi_master_mode; // see RL10
		pb_value_override_val[pabm_pkg::PB_MOSI] = SPI_MASTER_OUT; // see RL10
		pb_value_override_en[pabm_pkg::PB_MISO] = spi_slave_mode; // see RL10
		pb_value_override_val[pabm_pkg::PB_MISO] = SPI_SLAVE_OUT; // see RL10
		// compare output, also pwm; shows only if direction bit is set
		pb_value_override_en[pabm_pkg::PB_T0CMP] = timer0_cmp_en; // see RL11 RL12
		pb_value_override_val[pabm_pkg::PB_T0CMP] = TIMER0_COMPARE_OUT; // see RL11 RL12
		pb_input_enable_override_en[pabm_pkg::PB_IRQ2] = ext_irq2_en; // see RL14
		pb_input_enable_override_val[pabm_pkg::PB_IRQ2] = 1'b1; // see RL14
		// serial clock out only in sync mode; direction bit picks in/out
		pb_value_override_en[pabm_pkg::PB_SCLK] = serial_sync_select; // see RL17
		pb_value_override_val[pabm_pkg::PB_SCLK] = SERIAL_PORT_CLOCK_OUT; // see RL16
	end

	generate
		for (gi = 0; gi < pabm_pkg::PIN_COUNT; gi++) begin : g_pb
			pabm_pin_ctrl u_pin (
				.pin_direction_bit(pb_dir_reg[gi]),
				.pin_output_bit(pb_out_reg[gi]),
				.global_pullup_off(global_pullup_off),
				.sleep_active(SLEEP_ACTIVE),
				.pullup_override_en(pb_pullup_override_en[gi]),
				.pullup_override_val(pb_pullup_override_val[gi]),
				.direction_override_en(pb_direction_override_en[gi]),
				.direction_override_val(1'b0),
				.value_override_en(pb_value_override_en[gi]),
				.value_override_val(pb_value_override_val[gi]),
				.input_enable_override_en(pb_input_enable_override_en[gi]),
				.input_enable_override_val(pb_input_enable_override_val[gi]),
				.pullup_on(PB_PULLUP[gi]),
				.drive_on(pb_drive_on[gi]),
				.drive_level(PB_PIN_OUT[gi]),
				.input_on(pb_input_on[gi]));
		end
	endgenerate
	assign PB_PIN_OE_N = ~pb_drive_on;
	assign pb_in_gated = PB_PIN_IN & pb_input_on;

	// ----------------------------------------------------------------
	// digital inputs to peripherals (unsynchronised, before sync)
	// ----------------------------------------------------------------
	assign SPI_CLK_IN = pb_in_gated[pabm_pkg::PB_SCK];
	assign SPI_MASTER_IN = pb_in_gated[pabm_pkg::PB_MISO]; // see RL10
	assign SPI_SLAVE_IN = pb_in_gated[pabm_pkg::PB_MOSI]; // see RL10
	// slave logic is live only while select pin is low
	assign SPI_SLAVE_ACTIVE = spi_slave_mode &&
		!pb_in_gated[pabm_pkg::PB_SEL]; // see RL8
	// analog comparator taps the pad directly
	assign COMPARATOR_POS_IN = PB_PIN_IN[pabm_pkg::PB_IRQ2];
	assign COMPARATOR_NEG_IN = PB_PIN_IN[pabm_pkg::PB_T0CMP];
	assign EXT_IRQ2_IN = pb_in_gated[pabm_pkg::PB_IRQ2]; // see RL14
	assign TIMER1_COUNT_IN = pb_in_gated[pabm_pkg::PB_T1CNT]; // see RL15
	assign TIMER0_COUNT_IN = pb_in_gated[pabm_pkg::PB_SCLK]; // see RL16
	assign SERIAL_PORT_CLOCK_IN = serial_sync_select &&
		pb_in_gated[pabm_pkg::PB_SCLK]; // see RL17

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_pullup_global_off: assert property (@(posedge CLK) disable iff (RESET)
		global_pullup_off |-> PB_PULLUP == 8'h00 && PA_PULLUP == 8'h00)
		else $error("pull-up on while globally disabled"); // see RL1
	a_misc_bit4_zero: assert property (@(posedge CLK) disable iff (RESET)
		WR && ADDR == pabm_pkg::ADDR_MISC_CTRL |=> !misc_ctrl_reg[4] &&
		misc_ctrl_reg[7:5] == $past(WDATA[7:5]))
		else $error("misc control write wrong"); // see RL2
	a_porta_no_override: assert property (@(posedge CLK) disable iff (RESET)
		PA_PIN_OE_N == ~pa_dir_reg && PA_ANALOG_PATH == PA_PIN_IN &&
		PA_PULLUP == (~pa_dir_reg & pa_out_reg & {8{!global_pullup_off}}))
		else $error("port a overridden"); // see RL3
	a_slave_inputs: assert property (@(posedge CLK) disable iff (RESET)
		spi_slave_mode |-> PB_PIN_OE_N[7] && PB_PIN_OE_N[5] && PB_PIN_OE_N[4])
		else $error("slave pin driven"); // see RL5 RL7 RL8
	a_master_miso_in: assert property (@(posedge CLK) disable iff (RESET)
		spi_master_mode |-> PB_PIN_OE_N[6] &&
		PB_PIN_OE_N[7] == !pb_dir_reg[7])
		else $error("master pin direction wrong"); // see RL5 RL6
	a_forced_pullup: assert property (@(posedge CLK) disable iff (RESET)
		spi_slave_mode |-> PB_PULLUP[7] ==
		(pb_out_reg[7] && !global_pullup_off))
		else $error("forced input pull-up wrong"); // see RL9
	a_mosi_value: assert property (@(posedge CLK) disable iff (RESET)
		spi_master_mode && pb_dir_reg[5] |-> PB_PIN_OUT[5] == SPI_MASTER_OUT)
		else $error("mosi value wrong"); // see RL10
	a_compare_out: assert property (@(posedge CLK) disable iff (RESET)
		timer0_cmp_en && pb_dir_reg[3] |->
		PB_PIN_OUT[3] == TIMER0_COMPARE_OUT)
		else $error("compare output missing"); // see RL11
	a_irq2_input: assert property (@(posedge CLK) disable iff (RESET)
		ext_irq2_en |-> EXT_IRQ2_IN == PB_PIN_IN[2])
		else $error("irq 2 input blocked"); // see RL14
	a_sync_clock: assert property (@(posedge CLK) disable iff (RESET)
		serial_sync_select && pb_dir_reg[0] |->
		PB_PIN_OUT[0] == SERIAL_PORT_CLOCK_OUT && !PB_PIN_OE_N[0])
		else $error("serial clock not driven"); // see RL16 RL17
endmodule

// ### pabm_pad_model.sv
// pad model for one eight-pin port: own driver, outside source, pull-up
`timescale 1ns/1ps
module pabm_pad_model (
	input wire logic clk,
	input wire logic [7:0] oe_n,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pu_on,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pad
);
	logic [7:0] float_reg = 8'h00;
	// ------------------------------------------------------------
	// pad level
	// ------------------------------------------------------------
	// a floating pad must never settle to a convenient constant
	always_ff @(posedge clk) begin
		float_reg <= ~float_reg;
	end
	// the outside source only drives pins that the port leaves undriven
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad[i] = !oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
				pu_on[i] ? 1'b1 : float_reg[i];
		end
	end
endmodule

// ### pabm_top_tb_top.sv
// self-checking bench for the port a/b alternate function multiplexer
`timescale 1ns/1ps
module pabm_top_tb_top;
	logic clk, reset, wr, rd, sleep, sck_o, mo_o, so_o, t0c, xo;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, pa_pad, pa_out, pa_oe_n, pa_pu, pa_an;
	logic [7:0] pb_pad, pb_out, pb_oe_n, pb_pu, en_a, val_a, en_b, val_b;
	logic sck_i, mi, si, s_act, c_pos, c_neg, irq2, t1c, t0i, xi;
	logic [2:0] trig;
	logic c_mux, p2, p10;
	int err_count = 0;
	int samples_checked = 0;
	// ------------------------------------------------------------
	// design and pads
	// ------------------------------------------------------------
	pabm_top i_pabm_top (.CLK(clk), .RESET(reset), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.SLEEP_ACTIVE(sleep), .PA_PIN_IN(pa_pad), .PA_PIN_OUT(pa_out),
		.PA_PIN_OE_N(pa_oe_n), .PA_PULLUP(pa_pu), .PA_ANALOG_PATH(pa_an),
		.PB_PIN_IN(pb_pad), .PB_PIN_OUT(pb_out), .PB_PIN_OE_N(pb_oe_n),
		.PB_PULLUP(pb_pu), .SPI_CLK_OUT(sck_o), .SPI_MASTER_OUT(mo_o),
		.SPI_SLAVE_OUT(so_o), .SPI_CLK_IN(sck_i), .SPI_MASTER_IN(mi),
		.SPI_SLAVE_IN(si), .SPI_SLAVE_ACTIVE(s_act),
		.TIMER0_COMPARE_OUT(t0c), .COMPARATOR_POS_IN(c_pos),
		.COMPARATOR_NEG_IN(c_neg), .EXT_IRQ2_IN(irq2),
		.TIMER1_COUNT_IN(t1c), .TIMER0_COUNT_IN(t0i),
		.SERIAL_PORT_CLOCK_OUT(xo), .SERIAL_PORT_CLOCK_IN(xi),
		.CONV_TRIGGER_SEL(trig), .COMPARATOR_MUX_EN(c_mux),
		.TIMER2_PRESCALE_RESET(p2), .TIMER10_PRESCALE_RESET(p10));
	pabm_pad_model u_pad_a (.clk(clk), .oe_n(pa_oe_n), .pin_out(pa_out),
		.pu_on(pa_pu), .ext_en(en_a), .ext_val(val_a), .pad(pa_pad));
	pabm_pad_model u_pad_b (.clk(clk), .oe_n(pb_oe_n), .pin_out(pb_out),
		.pu_on(pb_pu), .ext_en(en_b), .ext_val(val_b), .pad(pb_pad));
	// ------------------------------------------------------------
	// bus, compare and closing tasks
	// ------------------------------------------------------------
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			$display("[FAIL] %0t byte got %h exp %h", $time, g, e);
			err_count++;
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			$display("[FAIL] %0t bit got %b exp %b", $time, g, e);
			err_count++;
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk8(rdata, e);
	endtask
	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		{sleep, sck_o, mo_o, so_o, t0c, xo} <= 6'h00;
		{en_a, en_b} <= 16'h0000;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 8; i++) begin
			if (i != 3 && i != 6) rd_chk(i[3:0], 8'h00);
		end
		chk8(pb_oe_n, 8'hFF);
		chk8(pb_pu, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_misc();
		wr_reg(pabm_pkg::ADDR_MISC_CTRL, 8'hFF);
		rd_chk(pabm_pkg::ADDR_MISC_CTRL, 8'hEF);
		chk8({2'h0, trig, c_mux, p2, p10}, 8'h3F);
		// read data must fall back to zero one cycle after the strobe
		@(posedge clk);
		#1;
		chk8(rdata, 8'h00);
		wr_reg(4'h9, 8'h55);
		rd_chk(4'h9, 8'h00);
		do_reset();
		rd_chk(pabm_pkg::ADDR_MISC_CTRL, 8'h00);
		$display("test misc register done");
	endtask
	task automatic t_pullup();
		wr_reg(pabm_pkg::ADDR_PORTA_OUT, 8'hFF);
		wr_reg(pabm_pkg::ADDR_PORTB_OUT, 8'hFF);
		chk8(pa_pu & pb_pu, 8'hFF);
		wr_reg(pabm_pkg::ADDR_MISC_CTRL, 8'h04);
		chk8(pa_pu | pb_pu, 8'h00);
		wr_reg(pabm_pkg::ADDR_MISC_CTRL, 8'h00);
		// outside drive wins over the weak pull-ups on the low nibble
		@(posedge clk);
		en_a <= 8'h0F;
		val_a <= 8'h03;
		wr_reg(pabm_pkg::ADDR_PORTA_DIR, 8'hF0);
		chk8(pa_pu, 8'h0F);
		chk8(pa_oe_n, 8'h0F);
		wr_reg(pabm_pkg::ADDR_PORTA_OUT, 8'h5A);
		chk8(pa_out, 8'h50);
		// outputs held still while the converter channels are sampled
		chk8(pa_an, 8'h53);
		rd_chk(pabm_pkg::ADDR_PORTA_IN, 8'h53);
		$display("test pull-up and port a done");
	endtask
	task automatic t_spi_slave();
		do_reset();
		wr_reg(pabm_pkg::ADDR_PORTB_DIR, 8'hFF);
		wr_reg(pabm_pkg::ADDR_PORTB_OUT, 8'hFF);
		@(posedge clk);
		so_o <= 1'b1;
		en_b <= 8'hB0;
		val_b <= 8'h20;
		wr_reg(pabm_pkg::ADDR_PERIPH_CTRL, 8'h01);
		chk8(pb_oe_n, 8'hB0);
		chk8(pb_pu, 8'hB0);
		chk8(pb_out, 8'h4F);
		chk8({5'h00, s_act, si, sck_i}, 8'h06);
		@(posedge clk);
		so_o <= 1'b0;
		val_b <= 8'h90;
		#1;
		chk8(pb_out, 8'h0F);
		chk8({5'h00, s_act, si, sck_i}, 8'h01);
		wr_reg(pabm_pkg::ADDR_MISC_CTRL, 8'h04);
		chk8(pb_pu, 8'h00);
		$display("test spi slave done");
	endtask
	task automatic t_spi_master();
		do_reset();
		wr_reg(pabm_pkg::ADDR_PORTB_DIR, 8'hF0);
		@(posedge clk);
		sck_o <= 1'b1;
		en_b <= 8'h40;
		val_b <= 8'h40;
		wr_reg(pabm_pkg::ADDR_PERIPH_CTRL, 8'h03);
		chk8(pb_oe_n, 8'h4F);
		chk8(pb_out, 8'h80);
		chk1(mi, 1'b1);
		chk8(pb_pu, 8'h00);
		wr_reg(pabm_pkg::ADDR_PORTB_OUT, 8'h40);
		chk8(pb_pu, 8'h40);
		@(posedge clk);
		sck_o <= 1'b0;
		mo_o <= 1'b1;
		#1;
		chk8(pb_out, 8'h20);
		wr_reg(pabm_pkg::ADDR_PORTB_DIR, 8'h00);
		chk8(pb_oe_n, 8'hFF);
		$display("test spi master done");
	endtask
	task automatic t_timer0();
		do_reset();
		// comparator pins left as inputs with pull-ups off
		@(posedge clk);
		t0c <= 1'b1;
		en_b <= 8'h0C;
		val_b <= 8'h08;
		#1;
		chk8({6'h00, c_neg, c_pos}, 8'h02);
		@(posedge clk);
		en_b <= 8'h00;
		wr_reg(pabm_pkg::ADDR_PORTB_DIR, 8'h08);
		chk8(pb_out, 8'h00);
		wr_reg(pabm_pkg::ADDR_PERIPH_CTRL, 8'h08);
		chk8(pb_out, 8'h08);
		@(posedge clk);
		t0c <= 1'b0;
		#1;
		chk8(pb_out, 8'h00);
		$display("test timer compare done");
	endtask
	task automatic t_irq_sleep();
		do_reset();
		@(posedge clk);
		sleep <= 1'b1;
		en_b <= 8'h07;
		val_b <= 8'h07;
		#1;
		chk8({5'h00, irq2, t1c, t0i}, 8'h00);
		wr_reg(pabm_pkg::ADDR_PERIPH_CTRL, 8'h10);
		chk8({5'h00, irq2, t1c, t0i}, 8'h04);
		@(posedge clk);
		sleep <= 1'b0;
		#1;
		chk8({5'h00, irq2, t1c, t0i}, 8'h07);
		$display("test interrupt and sleep done");
	endtask
	task automatic t_serial_clk();
		do_reset();
		wr_reg(pabm_pkg::ADDR_PORTB_DIR, 8'h01);
		@(posedge clk);
		xo <= 1'b1;
		#1;
		chk8(pb_out, 8'h00);
		wr_reg(pabm_pkg::ADDR_PERIPH_CTRL, 8'h04);
		chk8(pb_out, 8'h01);
		wr_reg(pabm_pkg::ADDR_PORTB_DIR, 8'h00);
		@(posedge clk);
		en_b <= 8'h01;
		val_b <= 8'h01;
		#1;
		chk8({5'h00, pb_oe_n[0], xi, t0i}, 8'h07);
		wr_reg(pabm_pkg::ADDR_PERIPH_CTRL, 8'h00);
		chk8({6'h00, xi, t0i}, 8'h01);
		$display("test serial clock done");
	endtask
	// ------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (4000) @(posedge clk);
		err_count++;
		close_out();
	end
	initial begin
		{reset, wr, rd, sleep, sck_o, mo_o, so_o, t0c, xo} = 9'h100;
		addr = 4'h0;
		wdata = 8'h00;
		{en_a, val_a, en_b, val_b} = 32'h00000000;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_misc();
		t_pullup();
		t_spi_slave();
		t_spi_master();
		t_timer0();
		t_irq_sleep();
		t_serial_clk();
		close_out();
	end
endmodule
